// ### core/branch_exit_io_instr_exec.sv
// Executes counted and bit branches, links, exit and central/adapter I/O
`timescale 1ns/1ps
`include "bx_exec_cfg.svh"
module branch_exit_io_instr_exec (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_exec,        // One-cycle start of an instruction
  input  wire logic [15:0] i_instr,       // First halfword
  input  wire logic [15:0] i_instr2,      // Second halfword of 4-byte forms
  input  wire logic [4:0]  i_irq_pend,    // Pending request, bit k = level k+1
  input  wire logic [4:0]  i_irq_mask,    // Mask, bit k = level k+1
  input  wire logic [2:0]  i_resume_level,// Level that was interrupted
  input  wire logic [23:0] i_ext_rdata,   // External register read data
  input  wire logic        i_adp_ack,     // Adapter answer
  input  wire logic [23:0] i_adp_rdata,   // Adapter read data
  input  wire logic [3:0]  i_bus_addr,
  input  wire logic [23:0] i_bus_wdata,
  input  wire logic        i_bus_wr,
  input  wire logic        i_bus_rd,
  output logic      [23:0] o_bus_rdata,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_ext_rd,
  output logic             o_ext_wr,
  output logic      [6:0]  o_ext_addr,
  output logic      [23:0] o_ext_wdata,
  output logic             o_adp_req,
  output logic      [15:0] o_adp_cmd,
  output logic      [23:0] o_adp_wdata,
  output logic             o_l1_req,
  output logic             o_l5_io_err,
  output logic             o_invalid_op,
  output logic             o_exit,
  output logic      [4:0]  o_clr_entered,
  output logic             o_supervisor_call_level4,
  output logic             o_group_load,
  output logic      [2:0]  o_group_sel,
  output logic             o_trace_pass,
  output logic      [2:0]  o_trace_level
);

  // ==========================================================
  // State and storage
  bx_exec_pkg::gpr_t        gpr_reg [0:7];  // Work registers, 0 is the pointer
  bx_exec_pkg::exec_state_t st_reg;         // Sequencer
  logic [4:0]               ctrl_reg;       // Level, C and Z latches
  logic [2:0]               idx_reg;        // Destination held across a wait
  logic                     adp_in_reg;     // Adapter transfer is an input
  logic [1:0]               err_reg;        // Last invalid-op / level-5 error

  // ==========================================================
  // Decode
  wire start    = i_exec && (st_reg == bx_exec_pkg::ST_IDLE);
  wire bal_sel  = i_instr[`F_MAJ] == `OPC_CNT && i_instr[`F_BAL_SUB] == `BAL_SUB;
  // Forms overlap; the link form wins over the counted form
  wire is_bal   = bal_sel;
  wire is_bct   = i_instr[`F_MAJ] == `OPC_CNT && i_instr[`F_MLO] && !bal_sel;
  wire is_bb    = i_instr[`F_TOP2] == `BB_TOP && i_instr[`F_ZBIT];
  wire rr_form  = !i_instr[`F_TOP] && !i_instr[`F_ZBIT];
  wire is_adapter_io_immediate_f = i_instr[`F_MAJ] == `ADAPTER_IO_IMMEDIATE_MAJ && i_instr[`F_LOW8] == `ADAPTER_IO_IMMEDIATE_LO;
  wire is_exit  = is_adapter_io_immediate_f && i_instr[`F_R1] == `R_IAR;
  wire is_adapter_io_immediate  = is_adapter_io_immediate_f && !is_exit;
  wire is_reg_branch_link  = rr_form && i_instr[`F_LOW8] == `REG_BRANCH_LINK_LO;
  wire is_ioh   = rr_form && i_instr[`F_LOW8] == `IOH_LO && !is_adapter_io_immediate_f;
  wire is_in    = rr_form && i_instr[`F_LOW4] == `IN_LO;
  wire is_out   = rr_form && i_instr[`F_LOW4] == `OUT_LO;

  // Register selects; odd select forces the low bit
  wire [2:0]  odd_idx = {i_instr[`F_RSEL], 1'b1};
  wire [2:0]  r1      = i_instr[`F_R1];
  wire [2:0]  r2      = i_instr[`F_R2];
  wire [2:0]  bal_idx = {1'b0, i_instr[`F_RSEL]};
  wire [23:0] odd_val = gpr_reg[odd_idx];
  wire [23:0] r1_val  = gpr_reg[r1];
  wire [23:0] r2_val  = gpr_reg[r2];
  wire [19:0] nsi     = gpr_reg[0][`GA_ADR];           // Already advanced
  wire [2:0]  lvl     = ctrl_reg[`CT_LVL];

  // ==========================================================
  // Relative target
  // Magnitude is six bits, so only 63 halfwords either way
  wire [19:0] disp_off = {13'h0000, i_instr[`F_MAG], 1'b0};
  wire [19:0] rel_tgt  = i_instr[`F_SGN] ? nsi - disp_off
                                         : nsi + disp_off;

  // ==========================================================
  // Counted branch: byte X passes through untouched
  wire [7:0]  cnt8    = odd_val[`GA_B0] - 8'h01;
  wire [15:0] cnt16   = odd_val[`GA_B01] - 16'h0001;
  wire        bct_n   = i_instr[`F_N];
  wire [23:0] bct_val = bct_n ? {odd_val[`GA_BX], cnt16}
                              : {odd_val[`GA_BX], cnt8, odd_val[`GA_B1]};
  wire        bct_take = bct_n ? (cnt16 != 16'h0000) : (cnt8 != 8'h00);

  // ==========================================================
  // Bit test: mask value 0 names the leftmost bit
  wire [2:0]  bb_m     = {i_instr[`F_MHI], i_instr[`F_MLO]};
  wire [7:0]  bb_byte  = i_instr[`F_N] ? odd_val[`GA_B1] : odd_val[`GA_B0];
  wire        bb_bit   = bb_byte[`BIT_MSB - bb_m];

  // ==========================================================
  // Central register I/O checks
  wire [6:0] eaddr   = {i_instr[`F_R2], i_instr[`F_ELO]};
  wire lvl_bad       = lvl > `LVL_IO_MAX;
  wire inv_com       = (eaddr >= `INV_A_LO && eaddr <= `INV_A_HI) ||
                       (eaddr >= `INV_B_LO && eaddr <= `INV_B_HI) ||
                       (eaddr >= `INV_C_LO && eaddr <= `INV_C_HI);
  wire inv_in        = inv_com || eaddr == `INV_IN;
  wire inv_out       = inv_com || eaddr == `INV_OUT;
  wire io_lvl_err    = (is_in || is_out || is_ioh || is_adapter_io_immediate) && lvl_bad;
  wire io_inv        = !lvl_bad && ((is_in && inv_in) || (is_out && inv_out));
  wire in_go         = is_in && !lvl_bad && !inv_in;
  wire out_go        = is_out && !lvl_bad && !inv_out;
  wire adp_go        = (is_ioh || is_adapter_io_immediate) && !lvl_bad;
  // Register form takes the command from R2, immediate from halfword two
  wire [15:0] adp_cmd = is_ioh ? r2_val[`GA_B01] : i_instr2;
  wire [2:0]  adp_idx = is_ioh ? r1 : r1;

  // ==========================================================
  // Exit: pick the next level, highest priority is level 1
  wire [4:0] svc_vec  = (lvl == `LVL_BG) ? `SVC_VEC : 5'h00;
  wire [4:0] pend_eff = (i_irq_pend | svc_vec) & ~i_irq_mask;
  wire       other    = |(i_irq_pend & ~i_irq_mask);

  function automatic logic [2:0] first_lvl(input logic [4:0] v);
    logic [2:0] r;
    r = `LVL_BG;
    for (int k = 4; k >= 0; k--)
    begin
      if (v[k])
      begin
        r = 3'(k + 1);
      end
    end
    return r;
  endfunction : first_lvl

  // With nothing eligible, level 5 resumes even after a call request
  wire [2:0] exit_next = first_lvl(pend_eff);
  wire [4:0] lvl_hot   = 5'(5'h01 << (lvl - 3'h1));

  // ==========================================================
  // Write ports: general port A and pointer port
  logic        a_we;
  logic [2:0]  a_idx;
  logic [23:0] a_val;
  logic        p_we;
  logic [19:0] p_val;

  // Port selection per instruction
  always_comb
  begin
    a_we  = 1'b0;
    a_idx = odd_idx;
    a_val = bct_val;
    p_we  = 1'b0;
    p_val = rel_tgt;
    if (st_reg == bx_exec_pkg::ST_EXT_WAIT)
    begin
      // Destination 0 makes this a branch
      a_we  = 1'b1;
      a_idx = idx_reg;
      a_val = i_ext_rdata;
    end
    else if (st_reg == bx_exec_pkg::ST_ADP_WAIT)
    begin
      // Byte X reads back as zero on adapter input
      a_we  = i_adp_ack && adp_in_reg;
      a_idx = idx_reg;
      a_val = {8'h00, i_adp_rdata[`GA_B01]};
    end
    else if (start && is_bct)
    begin
      a_we  = 1'b1;
      p_we  = bct_take;
    end
    else if (start && is_bb)
    begin
      p_we  = bb_bit;
    end
    else if (start && is_reg_branch_link)
    begin
      // Target was read before the link lands, so R1 = R2 works
      a_we  = r1 != `R_IAR;
      a_idx = r1;
      a_val = {4'h0, nsi};
      p_we  = r2 != `R_IAR;
      p_val = r2_val[`GA_ADR];
    end
    else if (start && is_bal)
    begin
      a_we  = bal_idx != `R_IAR;
      a_idx = bal_idx;
      a_val = {4'h0, nsi};
      p_we  = 1'b1;
      p_val = {i_instr[`F_EXT], i_instr2};
    end
  end

  // ==========================================================
  // Work registers; the pointer port wins over port A on register 0
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < 8; k++)
      begin
        gpr_reg[k] <= 24'h000000;
      end
    end
    else
    begin
      if (i_bus_wr && !i_bus_addr[3])
      begin
        gpr_reg[i_bus_addr[2:0]] <= i_bus_wdata;
      end
      if (a_we)
      begin
        gpr_reg[a_idx] <= a_val;
      end
      if (p_we)
      begin
        gpr_reg[0] <= {4'h0, p_val}; // Whole new address, top nibble clear
      end
    end
  end

  // ==========================================================
  // Sequencer and held destination
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg     <= bx_exec_pkg::ST_IDLE;
      idx_reg    <= 3'h0;
      adp_in_reg <= 1'b0;
    end
    else
    begin
      case (st_reg)
        bx_exec_pkg::ST_IDLE:
        begin
          if (start && in_go)
          begin
            st_reg  <= bx_exec_pkg::ST_EXT_WAIT;
            idx_reg <= r1;
          end
          else if (start && adp_go)
          begin
            st_reg     <= bx_exec_pkg::ST_ADP_WAIT;
            idx_reg    <= adp_idx;
            adp_in_reg <= adp_cmd[`ADP_DIR];
          end
        end
        bx_exec_pkg::ST_EXT_WAIT: st_reg <= bx_exec_pkg::ST_IDLE;
        bx_exec_pkg::ST_ADP_WAIT:
        begin
          // No timeout here: a silent adapter holds the block busy
          if (i_adp_ack)
          begin
            st_reg <= bx_exec_pkg::ST_IDLE;
          end
        end
        default: st_reg <= bx_exec_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Control latches; only software writes C and Z
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_reg <= `CTRL_RST;
    end
    else if (start && is_exit)
    begin
      ctrl_reg[`CT_LVL] <= exit_next;
    end
    else if (i_bus_wr && i_bus_addr == `RA_CTRL)
    begin
      ctrl_reg <= i_bus_wdata[4:0];
    end
  end

  // ==========================================================
  // Pulses and held outbound data
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_done        <= 1'b0;
      o_ext_rd      <= 1'b0;
      o_ext_wr      <= 1'b0;
      o_ext_addr    <= 7'h00;
      o_ext_wdata   <= 24'h000000;
      o_adp_req     <= 1'b0;
      o_adp_cmd     <= 16'h0000;
      o_adp_wdata   <= 24'h000000;
      o_l1_req      <= 1'b0;
      o_l5_io_err   <= 1'b0;
      o_invalid_op  <= 1'b0;
      o_exit        <= 1'b0;
      o_clr_entered <= 5'h00;
      o_supervisor_call_level4      <= 1'b0;
      o_group_load  <= 1'b0;
      o_group_sel   <= `LVL_BG;
      o_trace_pass  <= 1'b0;
      o_trace_level <= `LVL_BG;
      err_reg       <= 2'h0;
    end
    else
    begin
      o_done        <= (start && !in_go && !adp_go)
                       || st_reg == bx_exec_pkg::ST_EXT_WAIT
                       || (st_reg == bx_exec_pkg::ST_ADP_WAIT && i_adp_ack);
      o_ext_rd      <= start && in_go;
      o_ext_wr      <= start && out_go;
      o_adp_req     <= start && adp_go;
      o_l1_req      <= start && (io_lvl_err || io_inv);
      o_l5_io_err   <= start && io_lvl_err;
      o_invalid_op  <= start && io_inv;
      o_exit        <= start && is_exit;
      o_clr_entered <= (start && is_exit) ? lvl_hot : 5'h00;
      o_supervisor_call_level4      <= start && is_exit && lvl == `LVL_BG;
      o_group_load  <= start && is_exit;
      o_trace_pass  <= start && is_exit && other && lvl != `LVL_BG;
      if (start && (in_go || out_go))
      begin
        o_ext_addr  <= eaddr;
        o_ext_wdata <= r1_val;
      end
      if (start && adp_go)
      begin
        o_adp_cmd   <= adp_cmd;
        o_adp_wdata <= r1_val;
      end
      if (start && is_exit)
      begin
        o_group_sel   <= exit_next;
        o_trace_level <= i_resume_level;
      end
      if (start)
      begin
        err_reg <= {io_lvl_err, io_inv};
      end
    end
  end

  // ==========================================================
  // Register port read, data valid only the cycle after the strobe
  wire [23:0] rd_mux = !i_bus_addr[3] ? gpr_reg[i_bus_addr[2:0]] :
                       (i_bus_addr == `RA_CTRL) ? {19'h00000, ctrl_reg} :
                       (i_bus_addr == `RA_STAT) ? {18'h00000, o_group_sel, err_reg, o_busy} :
                       24'h000000;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_bus_rdata <= 24'h000000;
    end
    else
    begin
      o_bus_rdata <= i_bus_rd ? rd_mux : 24'h000000;
    end
  end

  assign o_busy = st_reg != bx_exec_pkg::ST_IDLE;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_cz_hold: assert property (!(i_bus_wr && i_bus_addr == `RA_CTRL) |=>
    $stable(ctrl_reg[`CT_C]) && $stable(ctrl_reg[`CT_Z])) else $error("C or Z changed");
  a_bct_fall: assert property (start && is_bct && !i_instr[`F_N] &&
    odd_val[`GA_B0] == 8'h01 |=> $stable(gpr_reg[0])) else $error("count branch taken at zero");
  a_bct_wrap: assert property (start && is_bct && i_instr[`F_N] &&
    odd_val[`GA_B01] == 16'h0000 |=> gpr_reg[$past(odd_idx)][`GA_B01] == 16'hFFFF)
    else $error("count did not wrap");
  a_bb_forward: assert property (start && is_bb && bb_bit && !i_instr[`F_SGN] |=>
    gpr_reg[0][`GA_ADR] == 20'($past(nsi) + {$past(i_instr[`F_MAG]), 1'b0}))
    else $error("bit branch target wrong");
  a_reg_branch_link_src0: assert property (start && is_reg_branch_link && r2 == `R_IAR && r1 != `R_IAR |=>
    $stable(gpr_reg[0])) else $error("branch from register 0");
  a_exit_svc: assert property (start && is_exit && lvl == `LVL_BG |=>
    o_supervisor_call_level4 && o_exit && o_group_load) else $error("no level-4 call on exit");
  a_exit_mask4: assert property (start && is_exit && lvl == `LVL_BG && i_irq_mask[3] &&
    (i_irq_pend[2:0] & ~i_irq_mask[2:0]) == 3'h0 |=> o_group_sel == `LVL_BG)
    else $error("left level 5 while level 4 masked");
  a_io_lvl5: assert property (start && (is_in || is_out) && lvl_bad |=>
    o_l1_req && o_l5_io_err && !o_ext_rd && !o_ext_wr) else $error("I/O ran at level 5");
  a_in_invalid: assert property (start && is_in && !lvl_bad && inv_in |=>
    o_invalid_op && o_l1_req && !o_ext_rd) else $error("invalid input executed");
  a_out_invalid: assert property (start && is_out && !lvl_bad && inv_out |=>
    o_invalid_op && !o_ext_wr) else $error("invalid output executed");
  a_in_seq: assert property (start && in_go |=> o_ext_rd ##1 o_done)
    else $error("input sequence wrong");

endmodule : branch_exit_io_instr_exec

// ### core/bx_exec_cfg.svh
// Constants for the branch, exit and I/O execution block
`ifndef BX_EXEC_CFG_SVH
`define BX_EXEC_CFG_SVH
// Widths and register byte lanes
`define GPR_W      24
`define ADDR_W     20
`define GA_BX      23:16
`define GA_B0      15:8
`define GA_B1      7:0
`define GA_B01     15:0
`define GA_ADR     19:0
// Instruction fields, bit 0 of the manual is bit 15 here
`define F_TOP      15
`define F_TOP2     15:14
`define F_MAJ      15:11
`define F_R2       14:12
`define F_MHI      13:12
`define F_ZBIT     11
`define F_R1       10:8
`define F_RSEL     10:9
`define F_N        8
`define F_MLO      7
`define F_LOW8     7:0
`define F_ELO      7:4
`define F_BAL_SUB  8:5
`define F_MAG      6:1
`define F_EXT      4:1
`define F_LOW4     3:0
`define F_SGN      0
// Opcode values
`define OPC_CNT    5'h17
`define BB_TOP     2'h3
`define BAL_SUB    4'h4
`define ADAPTER_IO_IMMEDIATE_MAJ   5'h00
`define REG_BRANCH_LINK_LO    8'h40
`define IOH_LO     8'h50
`define ADAPTER_IO_IMMEDIATE_LO    8'h70
`define IN_LO      4'hC
`define OUT_LO     4'h4
`define R_IAR      3'h0
`define BIT_MSB    3'h7
`define ADP_DIR    0
// Program levels
`define LVL_IO_MAX 3'h4
`define LVL_BG     3'h5
`define SVC_VEC    5'h08
// Invalid external addresses
`define INV_A_LO   7'h28
`define INV_A_HI   7'h2F
`define INV_B_LO   7'h49
`define INV_B_HI   7'h4F
`define INV_C_LO   7'h60
`define INV_C_HI   7'h6F
`define INV_IN     7'h78
`define INV_OUT    7'h75
// Register port map
`define RA_CTRL    4'h8
`define RA_STAT    4'h9
`define CT_LVL     2:0
`define CT_C       3
`define CT_Z       4
`define CTRL_RST   5'h05
`endif

// ### core/bx_exec_pkg.sv
// Types shared by the execution block
package bx_exec_pkg;
  typedef enum {ST_IDLE, ST_EXT_WAIT, ST_ADP_WAIT} exec_state_t;
  typedef logic [2:0]  level_t;
  typedef logic [23:0] gpr_t;
endpackage : bx_exec_pkg

// ### sim/ext_adapter_model.sv
// Far-side model: external register file and an adapter that answers
`timescale 1ns/1ps
module ext_adapter_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_ext_rd,
  input  wire logic        i_ext_wr,
  input  wire logic [6:0]  i_ext_addr,
  input  wire logic [23:0] i_ext_wdata,
  output logic      [23:0] o_ext_rdata,
  input  wire logic        i_adp_req,
  input  wire logic [15:0] i_adp_cmd,
  output logic             o_adp_ack,
  output logic      [23:0] o_adp_rdata
);
  logic [23:0] mem [128]; // External registers
  logic [23:0] last_q;    // Last value shown on the read lines
  logic [3:0]  wait_q;    // Cycles left before the adapter answers
  logic        slow_q;    // Alternates prompt and slow answers
  // ==========================================================
  // Preset contents; the bench keeps the same pattern
  initial
  begin
    for (int a = 0; a < 128; a++)
      mem[a] = 24'(a) * 24'h010203 ^ 24'hA5C3E1;
    last_q = 24'h000000;
    wait_q = 4'h0;
    slow_q = 1'b0;
    o_adp_ack = 1'b0;
  end
  // ==========================================================
  // Unselected lines show the inverse, so a late sample cannot pass
  assign o_ext_rdata = i_ext_rd ? mem[i_ext_addr] : ~last_q;
  assign o_adp_rdata = o_adp_ack ? {8'hFF, ~i_adp_cmd} : ~last_q;
  // ==========================================================
  // Register writes and the adapter answer delay
  always @(posedge i_clk_sys)
  begin
    if (i_ext_wr)
      mem[i_ext_addr] <= i_ext_wdata;
    if (i_ext_rd)
      last_q <= mem[i_ext_addr];
    o_adp_ack <= (wait_q == 4'h1);
    if (i_adp_req)
    begin
      wait_q <= slow_q ? 4'h6 : 4'h1; // Prompt and slow in turn
      slow_q <= ~slow_q;
    end
    else if (wait_q != 4'h0)
      wait_q <= wait_q - 4'h1;
  end
endmodule : ext_adapter_model

// ### sim/testbench.sv
// Self-checking bench for the branch, exit and I/O execution block
`timescale 1ns/1ps
module testbench;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_exec = 1'b0, i_bus_wr = 1'b0, i_bus_rd = 1'b0;
  logic [15:0] i_instr = 16'h0000, i_instr2 = 16'h0000;
  logic [4:0]  i_irq_pend = 5'h00, i_irq_mask = 5'h00, o_clr_entered;
  logic [2:0]  i_resume_level = 3'h1, o_group_sel, o_trace_level;
  logic [3:0]  i_bus_addr = 4'h0;
  logic [23:0] i_bus_wdata = 24'h000000, o_bus_rdata, i_ext_rdata, o_ext_wdata;
  logic [23:0] i_adp_rdata, o_adp_wdata;
  logic [6:0]  o_ext_addr;
  logic [15:0] o_adp_cmd;
  logic o_busy, o_done, o_ext_rd, o_ext_wr, o_adp_req, i_adp_ack, o_l1_req, o_l5_io_err;
  logic o_invalid_op, o_exit, o_supervisor_call_level4, o_group_load, o_trace_pass;
  logic [23:0] g [8];    // Work register model
  logic [23:0] xm [128]; // External register mirror
  logic [4:0]  ctl;      // Control register model
  logic [5:0]  sts;      // Status model: group, level-5 error, invalid op, busy
  logic [9:0]  pv;       // Pulses seen during one instruction
  int errors = 0, samples_checked = 0, seed = 82111, lat;
  branch_exit_io_instr_exec branch_exit_io_instr_exec_i (.i_clk_sys, .i_rst, .i_exec, .i_instr,
    .i_instr2, .i_irq_pend, .i_irq_mask, .i_resume_level, .i_ext_rdata, .i_adp_ack,
    .i_adp_rdata, .i_bus_addr, .i_bus_wdata, .i_bus_wr, .i_bus_rd, .o_bus_rdata, .o_busy,
    .o_done, .o_ext_rd, .o_ext_wr, .o_ext_addr, .o_ext_wdata, .o_adp_req, .o_adp_cmd,
    .o_adp_wdata, .o_l1_req, .o_l5_io_err, .o_invalid_op, .o_exit, .o_clr_entered, .o_supervisor_call_level4,
    .o_group_load, .o_group_sel, .o_trace_pass, .o_trace_level);
  ext_adapter_model ext_adapter_model_i (.i_clk_sys(i_clk_sys), .i_ext_rd(o_ext_rd),
    .i_ext_wr(o_ext_wr), .i_ext_addr(o_ext_addr), .i_ext_wdata(o_ext_wdata),
    .o_ext_rdata(i_ext_rdata), .i_adp_req(o_adp_req), .i_adp_cmd(o_adp_cmd),
    .o_adp_ack(i_adp_ack), .o_adp_rdata(i_adp_rdata));
  always #20 i_clk_sys = ~i_clk_sys;
  // ==========================================================
  // Compare, bus cycles and instruction launch
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bwr(input logic [3:0] a, input logic [23:0] d);
    @(posedge i_clk_sys);
    i_bus_addr <= a;
    i_bus_wdata <= d;
    i_bus_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_bus_wr <= 1'b0;
  endtask : bwr
  task automatic brd(input logic [3:0] a, output logic [23:0] d);
    @(posedge i_clk_sys);
    i_bus_addr <= a;
    i_bus_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_bus_rd <= 1'b0;
    #1 d = o_bus_rdata; // Read data stand only in this cycle
  endtask : brd
  task automatic check_all;
    logic [23:0] v, k;
    for (int a = 0; a < 10; a++)
    begin
      brd(4'(a), v);
      // Pointer compares as a 20-bit address; control holds five bits, status six
      k = a == 0 ? 24'h0FFFFF : 24'hFFFFFF;
      if (a == 8) chk({19'h0, v[4:0]}, {19'h0, ctl});
      else if (a == 9) chk(v, {18'h0, sts});
      else chk(v & k, g[a] & k);
    end
  endtask : check_all
  task automatic run(input logic [15:0] ins, input logic [15:0] ins2);
    @(posedge i_clk_sys);
    i_instr <= ins;
    i_instr2 <= ins2;
    i_exec <= 1'b1;
    @(posedge i_clk_sys);
    i_exec <= 1'b0;
    pv = 10'h000;
    lat = 0;
    // Pulses stand only from their launching edge to the next, so look 1 ns into
    // every cycle from the taking edge on; a bounded wait gathers each pulse
    do
    begin
      if (lat > 0) @(posedge i_clk_sys);
      #1 lat++;
      pv |= {o_l1_req, o_l5_io_err, o_invalid_op, o_exit, o_supervisor_call_level4, o_group_load,
             o_trace_pass, o_ext_rd, o_ext_wr, o_adp_req};
    end while (o_done !== 1'b1 && lat < 40);
    chk({23'h0, o_done}, 24'h000001);
  endtask : run
  function automatic logic bad(input logic [6:0] e, input logic inp);
    return (e >= 7'h28 && e <= 7'h2F) || (e >= 7'h49 && e <= 7'h4F) || e[6:4] == 3'h6 ||
           e == (inp ? 7'h78 : 7'h75);
  endfunction : bad
  task automatic finish_test;
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // ==========================================================
  // Watchdog: far beyond the expected 16k cycles
  initial
  begin
    #(40 * 90000);
    errors++;
    finish_test();
  end
  // ==========================================================
  // Main sequence: every instruction kind in turn, with random operands
  initial
  begin
    logic [31:0] rv, rw;
    logic [23:0] v, t;
    logic [19:0] tgt;
    logic [15:0] cmd;
    logic [9:0]  ep;
    logic [4:0]  v5;
    logic [2:0]  r, r1, r2, m, sel;
    logic        tk, n, sg;
    logic [5:0]  mag;
    for (int a = 0; a < 128; a++) xm[a] = 24'(a) * 24'h010203 ^ 24'hA5C3E1;
    for (int a = 0; a < 8; a++) g[a] = 24'h000000;
    ctl = 5'h05;
    sts = 6'h28;
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    check_all();
    bwr(4'hC, 24'hFFFFFF); // Unmapped place ignores writes and reads zero
    brd(4'hC, v);
    chk(v, 24'h000000);
    for (int i = 0; i < 360; i++)
    begin
      for (int a = 0; a < 8; a++)
      begin
        rv = $random(seed);
        g[a] = a == 0 ? {4'h0, rv[19:0]} : (rv[26:25] == 2'b00 ? {rv[23:16], 16'h0} : rv[23:0]);
        bwr(4'(a), g[a]);
      end
      rv = $random(seed);
      rw = $random(seed);
      ctl = {rv[4:3], 3'(1 + rv[7:5] % 5)};
      bwr(4'h8, {19'h0, ctl});
      i_irq_pend <= rv[12:8];
      i_irq_mask <= rv[17:13];
      i_resume_level <= rv[20:18];
      r = {rv[22:21], 1'b1};
      {n, mag, sg} = rv[31:24];
      if (!n && mag[5:4] == 2'b00) mag[4] = 1'b1; // Keeps clear of the link form
      tgt = sg ? g[0][19:0] - {mag, 1'b0} : g[0][19:0] + {mag, 1'b0};
      {cmd, m, r2, r1} = rw[24:0];
      ep = 10'h000;
      case (i % 9)
        0: begin
          run({5'h17, r[2:1], n, 1'b1, mag, sg}, cmd);
          if (n) g[r][15:0] = g[r][15:0] - 16'h1;
          else g[r][15:8] = g[r][15:8] - 8'h1;
          tk = n ? g[r][15:0] != 16'h0 : g[r][15:8] != 8'h0;
          if (tk) g[0] = {4'h0, tgt};
        end
        1: begin
          run({2'b11, m[2:1], 1'b1, r[2:1], n, m[0], mag, sg}, cmd);
          if (n ? g[r][7 - m] : g[r][15 - m]) g[0] = {4'h0, tgt};
        end
        2: begin
          run({1'b0, r2, 1'b0, r1, 8'h40}, cmd);
          t = g[r2];
          if (r1 != 3'h0) g[r1] = g[0];
          if (r2 != 3'h0) g[0] = {4'h0, t[19:0]};
        end
        3: begin
          run({5'h17, r2[1:0], 4'h4, m, r1[0], 1'b0}, cmd);
          if (r2[1:0] != 2'b00) g[r2[1:0]] = g[0];
          g[0] = {4'h0, m, r1[0], cmd};
        end
        4: begin
          run(16'h0070, cmd);
          v5 = (rv[12:8] | (ctl[2:0] == 3'h5 ? 5'h08 : 5'h00)) & ~rv[17:13];
          sel = 3'h5;
          for (int k = 4; k >= 0; k--) if (v5[k]) sel = 3'(k + 1);
          tk = (rv[12:8] & ~rv[17:13]) != 5'h00 && ctl[2:0] != 3'h5;
          ep = {3'b000, 1'b1, ctl[2:0] == 3'h5, 1'b1, tk, 3'b000};
          chk({o_clr_entered, o_group_sel, o_trace_level},
              {5'(5'h01 << (ctl[2:0] - 3'h1)), sel, rv[20:18]});
          ctl[2:0] = sel;
          sts[5:3] = sel;
        end
        5, 6: begin
          tk = i % 9 == 5;
          if (ctl[2:0] == 3'h5) rw[22:16] = 7'h10;
          run({1'b0, rw[22:20], 1'b0, r1, rw[19:16], tk ? 4'hC : 4'h4}, cmd);
          if (ctl[2:0] == 3'h5) ep = 10'h300;
          else if (bad(rw[22:16], tk)) ep = 10'h280;
          else if (tk)
          begin
            ep = 10'h004;
            g[r1] = xm[rw[22:16]];
            chk(24'(lat), 24'h000002);
          end
          else
          begin
            ep = 10'h002;
            xm[rw[22:16]] = g[r1];
            chk(o_ext_wdata, g[r1]);
            chk({17'h0, o_ext_addr}, {17'h0, rw[22:16]});
          end
        end
        default: begin
          if (r1 == 3'h0) r1 = 3'h1;
          if (r2 == 3'h0) r2 = 3'h2;
          if (i % 9 == 7) cmd = g[r2][15:0];
          run(i % 9 == 7 ? {1'b0, r2, 1'b0, r1, 8'h50} : {5'h00, r1, 8'h70}, cmd);
          if (ctl[2:0] == 3'h5) ep = 10'h300;
          else
          begin
            ep = 10'h001;
            chk({8'h00, o_adp_cmd}, {8'h00, cmd});
            chk(cmd[0] ? 24'h0 : o_adp_wdata, cmd[0] ? 24'h0 : g[r1]);
            if (cmd[0]) g[r1] = {8'h00, ~cmd};
          end
          repeat (8) @(posedge i_clk_sys);
        end
      endcase
      chk({14'h0, pv}, {14'h0, ep});
      if (ep[9] || i % 9 < 5) chk(24'(lat), 24'h000001);
      sts[2:1] = ep[8:7];
      check_all();
    end
    finish_test();
  end
endmodule : testbench
